//--- bench/pifc_core_model.sv
// ****************************************
// Fast request source and its handler
// ****************************************
module pifc_core_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic go,
  input  wire logic fast_req_to_core,
  output logic      ext_fast_irq_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned age;
  int unsigned served;
  // Pin is pulled up, so a released source reads high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_fast_irq_pin <= 1'b1;
      age              <= 0;
      served           <= 0;
    end else if (go) begin
      ext_fast_irq_pin <= 1'b0;
      age              <= 0;
      served           <= 0;
    end else if (!ext_fast_irq_pin) begin
      age <= age + 1;
      if (fast_req_to_core) begin
        served <= served + 1;
      end
      // Handler withdraws at the source; unserved requests give up late
      if (served == 10 || age == 16) begin
        ext_fast_irq_pin <= 1'b1;
      end
    end
  end
endmodule : pifc_core_model

//--- bench/prioritized_irq_fiq_controller_test.sv
`include "pifc_params.svh"
module prioritized_irq_fiq_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clock, rst_n, wr, rd, go, fast_pin, src0, src3;
  logic [2:0]           outs;
  logic                 fast_req, normal_req, irq_out, rd_d1;
  logic [7:0]           addr;
  logic [31:0]          wdata, rdata, periph_req, req, wa, wb;
  logic [31:0]          exp_q[$];
  int                   bad_count, cmp_count;
  integer               seed;
  pifc_pkg::pifc_level_t lv [0:15];
  pifc_pkg::pifc_level_t best;
  pifc_pkg::pifc_src_t  win;

  pifc_controller i_pifc_controller (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .periph_req(periph_req),
    .ext_fast_irq_pin(fast_pin), .ext_source_0(src0), .ext_source_1(1'b1),
    .ext_source_2(1'b1), .ext_source_3(src3), .fast_req_to_core(fast_req),
    .normal_req_to_core(normal_req), .irq_out(irq_out));
  pifc_core_model i_pifc_core_model (.clock(clock), .rst_n(rst_n), .go(go),
    .fast_req_to_core(fast_req), .ext_fast_irq_pin(fast_pin));

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  // Strobe is dropped one edge later, so the next access never lands in the same step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask : wr_reg
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
  endtask : rd_exp
  task automatic pulse_go;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
  endtask : pulse_go
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // ****************************************
  // Clock, read monitor, watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) rd_d1 <= rd;
  // Level outputs are taken mid-cycle, clear of the edge that launches them
  always @(negedge clock) outs <= {fast_req, normal_req, irq_out};
  // Read data stand only in the cycle after the strobe
  always @(negedge clock) if (rd_d1 === 1'b1) check(rdata, exp_q.pop_front());
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0; wr = 1'b0; rd = 1'b0; go = 1'b0; src0 = 1'b1; src3 = 1'b1;
    addr = 8'h00; wdata = 32'h0; periph_req = 32'h0; seed = 32'h6eec;
    bad_count = 0; cmp_count = 0;
    idle(10);
    rst_n <= 1'b1;
    idle(1);
    wr_reg(`PIFC_OFF_ISTAT, 32'hffff_ffff);
    wr_reg(`PIFC_OFF_IMASK, 32'h0);
    pulse_go();
    idle(5);
    check({31'h0, outs[2]}, 32'h0);
    rd_exp(`PIFC_OFF_FRAW, 32'h1);
    rd_exp(`PIFC_OFF_FSTAT, 32'h0);
    check({31'h0, outs[0]}, 32'h0);
    wr_reg(`PIFC_OFF_IMASK, 32'h1);
    idle(2);
    check({31'h0, outs[0]}, 32'h1);
    idle(20);
    wr_reg(`PIFC_OFF_ISTAT, 32'h1);
    idle(2);
    check({31'h0, outs[0]}, 32'h0);
    wr_reg(`PIFC_OFF_FEN, 32'h1);
    pulse_go();
    idle(5);
    check({31'h0, outs[2]}, 32'h1);
    rd_exp(`PIFC_OFF_FSTAT, 32'h1);
    rd_exp(`PIFC_OFF_FRAW, 32'h1);
    idle(20);
    check({31'h0, outs[2]}, 32'h0);
    wr_reg(`PIFC_OFF_IMASK, 32'h0);
    wr_reg(8'h40, $random(seed));
    rd_exp(8'h40, 32'h0);
    // First pass has every level at zero, so nothing may request
    for (int it = 0; it < 8; it++) begin
      best = 3'h0;
      win = 5'h0;
      req = $random(seed);
      req[31:16] = 16'h0;
      for (int k = 0; k < 16; k++) begin
        lv[k] = (it == 0) ? 3'h0 : 3'($random(seed));
        if (req[k] && lv[k] != 3'h0 && lv[k] >= best) begin
          best = lv[k];
          win = 5'(k);
        end
        wa[4*(k%8) +: 4] = {1'b0, (k < 8) ? lv[k] : wa[4*(k%8) +: 3]};
        wb[4*(k%8) +: 4] = {1'b0, (k < 8) ? 3'h0 : lv[k]};
      end
      wr_reg(`PIFC_OFF_LVL_A, wa);
      wr_reg(`PIFC_OFF_LVL_B, wb);
      periph_req <= req;
      idle(3);
      check({31'h0, outs[1]}, {31'h0, best != 3'h0});
      rd_exp(`PIFC_OFF_IRN, {27'h0, win});
      idle(3);
      check({31'h0, outs[1]}, 32'h0);
      rd_exp(`PIFC_OFF_IRN, 32'h0);
      rd_exp(`PIFC_OFF_STACK, (32'h1 << best) & 32'hfe);
      rd_exp(`PIFC_OFF_ENCODE, {29'h0, best});
      periph_req <= 32'h0;
      wr_reg(`PIFC_OFF_POP, $random(seed));
      rd_exp(`PIFC_OFF_STACK, 32'h0);
      rd_exp(`PIFC_OFF_IRN, 32'h0);
    end
    wr_reg(`PIFC_OFF_LVL_A, 32'h0);
    wr_reg(`PIFC_OFF_LVL_B, 32'h0);
    wr_reg(`PIFC_OFF_LVL_U, 32'h3);
    periph_req <= 32'h0003_0000;
    idle(8);
    check({31'h0, outs[1]}, 32'h1);
    rd_exp(`PIFC_OFF_IRN, 32'd17);
    periph_req <= 32'h0;
    wr_reg(`PIFC_OFF_POP, 32'h0);
    wr_reg(`PIFC_OFF_LVL_U, 32'h0000_5000);
    wr_reg(`PIFC_OFF_DETECT, 32'h40);
    wr_reg(`PIFC_OFF_CLR, 32'd22);
    src0 <= 1'b0;
    idle(4);
    src0 <= 1'b1;
    idle(8);
    rd_exp(`PIFC_OFF_EDGE, 32'h0040_0000);
    check({31'h0, outs[1]}, 32'h1);
    rd_exp(`PIFC_OFF_IRN, 32'd22);
    wr_reg(`PIFC_OFF_EDGE, 32'h0040_0000);
    rd_exp(`PIFC_OFF_EDGE, 32'h0);
    rd_exp(`PIFC_OFF_ENCODE, 32'h5);
    wr_reg(`PIFC_OFF_POP, 32'h0);
    // High-level trigger on the last external source, whose source number is not evenly spaced
    wr_reg(`PIFC_OFF_LVL_U, 32'h6000_0000);
    wr_reg(`PIFC_OFF_DETECT, 32'h8000);
    idle(4);
    check({31'h0, outs[1]}, 32'h1);
    rd_exp(`PIFC_OFF_IRN, 32'd31);
    rd_exp(`PIFC_OFF_ENCODE, 32'h6);
    // Fast, edge and normal events have all been seen since the last clear
    rd_exp(`PIFC_OFF_ISTAT, 32'h7);
    idle(2);
    results();
  end
endmodule : prioritized_irq_fiq_controller_test

//--- inc/pifc_params.svh
`ifndef PIFC_PARAMS_SVH
`define PIFC_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PIFC_OFF_PEND      8'h00
`define PIFC_OFF_LVL_A     8'h04
`define PIFC_OFF_LVL_B     8'h08
`define PIFC_OFF_EDGE      8'h0c
`define PIFC_OFF_CLR       8'h10
`define PIFC_OFF_DETECT    8'h14
`define PIFC_OFF_LVL_U     8'h18
`define PIFC_OFF_IRN       8'h1c
`define PIFC_OFF_STACK     8'h20
`define PIFC_OFF_ENCODE    8'h24
`define PIFC_OFF_POP       8'h28
`define PIFC_OFF_FEN       8'h2c
`define PIFC_OFF_FRAW      8'h30
`define PIFC_OFF_FSTAT     8'h34
`define PIFC_OFF_ISTAT     8'h38
`define PIFC_OFF_IMASK     8'h3c

// ****************************************
// Field positions and reset values
// ****************************************
`define PIFC_FEN_BIT       0
`define PIFC_EV_FAST       0
`define PIFC_EV_EDGE       1
`define PIFC_EV_NORMAL     2
`define PIFC_RST_WORD      32'h0000_0000
`define PIFC_RST_STACK     8'h00
`define PIFC_DETECT_MASK   32'h0000_fcc0

`endif

//--- inc/pifc_pkg.sv
package pifc_pkg;
  typedef logic [2:0] pifc_level_t;
  typedef logic [4:0] pifc_src_t;
  typedef logic [1:0] pifc_ext_t;
endpackage : pifc_pkg

//--- rtl/pifc_controller.sv
// How it works
// - Enabled fast pin trigger raises the fast request line to the core.
// - Fast pin request sets the raw fast flag regardless of enable.
// - Relayed fast request also sets the fast status flag.
// - Normal request only when a pending level exceeds the serviced level.
// - Winner is the highest level; ties go to the larger source number.
// - Reading the source number masks requests at or below the accepted level.
// - A source with level zero is masked and never requests.
// - A detected edge sets that external source's edge pending bit.
// - Encode register gives the position of the highest stack bit.
// - On a qualifying request, load winning source number and raise request.
// - With nothing qualifying, no request and the source number reads zero.
// - Sources 16 to 31 share 3-bit levels in adjacent pairs.
// - Reading the source number clears it to zero.
// - Acknowledge pushes the level on the stack and drops the request.
// - Any write to the pop port clears the highest stack bit.
`include "pifc_params.svh"

module pifc_controller (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [31:0] periph_req,
  input  wire logic        ext_fast_irq_pin,
  input  wire logic        ext_source_0,
  input  wire logic        ext_source_1,
  input  wire logic        ext_source_2,
  input  wire logic        ext_source_3,
  output logic             fast_req_to_core,
  output logic             normal_req_to_core,
  output logic             irq_out
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic pifc_pkg::pifc_src_t ext_src(input pifc_pkg::pifc_ext_t k);
    unique case (k)
      2'h0: ext_src = 5'h16;
      2'h1: ext_src = 5'h1a;
      2'h2: ext_src = 5'h1c;
      2'h3: ext_src = 5'h1f;
    endcase
  endfunction : ext_src

  // Mode bit of each external source; polarity sits one above. The spacing is uneven.
  function automatic logic [3:0] cfg_pos(input pifc_pkg::pifc_ext_t k);
    unique case (k)
      2'h0: cfg_pos = 4'h6;
      2'h1: cfg_pos = 4'ha;
      2'h2: cfg_pos = 4'hc;
      2'h3: cfg_pos = 4'he;
    endcase
  endfunction : cfg_pos

  // Lower sources use one nibble each; upper sources share a field per pair
  function automatic pifc_pkg::pifc_level_t src_level(input pifc_pkg::pifc_src_t s,
                                                      input logic [31:0] la,
                                                      input logic [31:0] lb,
                                                      input logic [31:0] lu);
    logic [4:0] p;
    p = {s[2:0], 2'h0};
    if (s[4])
      src_level = lu[{s[3:1], 2'h0} +: 3];
    else if (s[3])
      src_level = lb[p +: 3];
    else
      src_level = la[p +: 3];
  endfunction : src_level

  function automatic pifc_pkg::pifc_level_t msb_pos(input logic [7:0] v);
    msb_pos = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (v[i])
        msb_pos = 3'(i);
    end
  endfunction : msb_pos

  // ****************************************
  // State
  // ****************************************
  logic [4:0]  sync1_reg,  sync1_next;
  logic [4:0]  sync2_reg,  sync2_next;
  logic [4:0]  prev_reg,   prev_next;
  logic [31:0] lvl_a_reg,  lvl_a_next;
  logic [31:0] lvl_b_reg,  lvl_b_next;
  logic [31:0] lvl_u_reg,  lvl_u_next;
  logic [31:0] detect_reg, detect_next;
  logic [3:0]  edge_reg,   edge_next;
  logic [4:0]  irn_reg,    irn_next;
  logic [2:0]  irn_lvl_reg, irn_lvl_next;
  logic [7:0]  stack_reg,  stack_next;
  logic        fen_reg,    fen_next;
  logic        fraw_reg,   fraw_next;
  logic        fstat_reg,  fstat_next;
  logic        freq_reg,   freq_next;
  logic        nreq_reg,   nreq_next;
  logic [2:0]  istat_reg,  istat_next;
  logic [2:0]  imask_reg,  imask_next;
  logic        irq_reg,    irq_next;
  logic [31:0] rdata_reg,  rdata_next;

  logic [31:0] req;
  logic [31:0] pend;
  logic [2:0]  best_lvl;
  logic [4:0]  best_src;
  logic [2:0]  current_level_encode;
  logic        qualify;
  logic        irn_rd;
  logic [3:0]  edge_set;
  logic [2:0]  ev;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [4:0] s;
    logic [2:0] l;
    logic       mode;
    logic       pol;
    s = 5'h0;
    l = 3'h0;
    mode = 1'b0;
    pol = 1'b0;
    // Pins are active low and pass two flops before anything looks at them
    sync1_next = ~{ext_source_3, ext_source_2, ext_source_1, ext_source_0,
                   ext_fast_irq_pin};
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
    lvl_a_next = lvl_a_reg;
    lvl_b_next = lvl_b_reg;
    lvl_u_next = lvl_u_reg;
    detect_next = detect_reg;
    edge_next = edge_reg;
    stack_next = stack_reg;
    fen_next = fen_reg;
    imask_next = imask_reg;
    irn_lvl_next = irn_lvl_reg;
    irn_rd = rd && (addr == `PIFC_OFF_IRN);
    req = periph_req;
    edge_set = 4'h0;

    // External sources: level or edge, either polarity
    for (int k = 0; k < 4; k++) begin
      s = ext_src(pifc_pkg::pifc_ext_t'(k));
      l = src_level(s, lvl_a_reg, lvl_b_reg, lvl_u_reg);
      mode = detect_reg[cfg_pos(pifc_pkg::pifc_ext_t'(k))];
      pol = detect_reg[cfg_pos(pifc_pkg::pifc_ext_t'(k)) + 4'h1];
      if (mode) begin
        // Sampled value is logic high when the pin is low
        edge_set[k] = (l != 3'h0) && (pol ? (!sync2_reg[k + 1] && prev_reg[k + 1])
                                          : (sync2_reg[k + 1] && !prev_reg[k + 1]));
        // A clear also re-arms the detector by dropping stale pending state
        if (wr && addr == `PIFC_OFF_EDGE && wdata[s])
          edge_next[k] = 1'b0;
        if (wr && addr == `PIFC_OFF_CLR && wdata[4:0] == s)
          edge_next[k] = 1'b0;
        if (edge_set[k])
          edge_next[k] = 1'b1;
        req[s] = edge_reg[k];
      end else begin
        req[s] = pol ? !sync2_reg[k + 1] : sync2_reg[k + 1];
      end
    end

    // Priority resolution
    best_lvl = 3'h0;
    best_src = 5'h0;
    for (int i = 0; i < 32; i++) begin
      l = src_level(5'(i), lvl_a_reg, lvl_b_reg, lvl_u_reg);
      pend[i] = req[i] && (l != 3'h0);
      if (pend[i] && l >= best_lvl) begin
        best_lvl = l;
        best_src = 5'(i);
      end
    end
    current_level_encode = msb_pos(stack_reg);
    qualify = best_lvl > current_level_encode;

    // Source number and normal request
    if (irn_rd) begin
      irn_next = 5'h0;
      nreq_next = 1'b0;
      if (nreq_reg)
        stack_next[irn_lvl_reg] = 1'b1;
    end else begin
      irn_next = qualify ? best_src : 5'h0;
      irn_lvl_next = qualify ? best_lvl : 3'h0;
      nreq_next = qualify;
    end
    if (wr && addr == `PIFC_OFF_POP && !irn_rd)
      stack_next[current_level_encode] = 1'b0;

    // Fast path: raw flag follows the pin, status and line need the enable
    fraw_next = sync2_reg[0];
    fstat_next = sync2_reg[0] && fen_reg;
    freq_next = sync2_reg[0] && fen_reg;

    // Software writes
    if (wr) begin
      unique case (addr)
        `PIFC_OFF_LVL_A:  lvl_a_next = wdata & 32'h7777_7777;
        `PIFC_OFF_LVL_B:  lvl_b_next = wdata & 32'h7777_7777;
        `PIFC_OFF_LVL_U:  lvl_u_next = wdata & 32'h7777_7777;
        `PIFC_OFF_DETECT: detect_next = wdata & `PIFC_DETECT_MASK;
        `PIFC_OFF_FEN:    fen_next = wdata[`PIFC_FEN_BIT];
        `PIFC_OFF_IMASK:  imask_next = wdata[2:0];
        default: ;
      endcase
    end

    // Sticky events; a set in the cycle of its clear wins
    ev[`PIFC_EV_FAST] = sync2_reg[0] && !fraw_reg;
    ev[`PIFC_EV_EDGE] = |edge_set;
    ev[`PIFC_EV_NORMAL] = nreq_next && !nreq_reg;
    istat_next = istat_reg;
    if (wr && addr == `PIFC_OFF_ISTAT)
      istat_next = istat_reg & ~wdata[2:0];
    istat_next = istat_next | ev;
    irq_next = |(istat_next & imask_next);

    // Read data, valid only in the cycle after the strobe
    rdata_next = 32'h0;
    if (rd) begin
      unique case (addr)
        `PIFC_OFF_PEND:   rdata_next = pend;
        `PIFC_OFF_LVL_A:  rdata_next = lvl_a_reg;
        `PIFC_OFF_LVL_B:  rdata_next = lvl_b_reg;
        `PIFC_OFF_LVL_U:  rdata_next = lvl_u_reg;
        `PIFC_OFF_EDGE:   rdata_next = 32'(edge_reg[3]) << 31 | 32'(edge_reg[2]) << 28
                                     | 32'(edge_reg[1]) << 26 | 32'(edge_reg[0]) << 22;
        `PIFC_OFF_DETECT: rdata_next = detect_reg;
        `PIFC_OFF_IRN:    rdata_next = {27'h0, irn_reg};
        `PIFC_OFF_STACK:  rdata_next = {24'h0, stack_reg};
        `PIFC_OFF_ENCODE: rdata_next = {29'h0, current_level_encode};
        `PIFC_OFF_FEN:    rdata_next = {31'h0, fen_reg};
        `PIFC_OFF_FRAW:   rdata_next = {31'h0, fraw_reg};
        `PIFC_OFF_FSTAT:  rdata_next = {31'h0, fstat_reg};
        `PIFC_OFF_ISTAT:  rdata_next = {29'h0, istat_reg};
        `PIFC_OFF_IMASK:  rdata_next = {29'h0, imask_reg};
        default:          rdata_next = 32'h0;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 5'h0;
      sync2_reg <= 5'h0;
      prev_reg <= 5'h0;
      lvl_a_reg <= `PIFC_RST_WORD;
      lvl_b_reg <= `PIFC_RST_WORD;
      lvl_u_reg <= `PIFC_RST_WORD;
      detect_reg <= `PIFC_RST_WORD;
      edge_reg <= 4'h0;
      irn_reg <= 5'h0;
      irn_lvl_reg <= 3'h0;
      stack_reg <= `PIFC_RST_STACK;
      fen_reg <= 1'b0;
      fraw_reg <= 1'b0;
      fstat_reg <= 1'b0;
      freq_reg <= 1'b0;
      nreq_reg <= 1'b0;
      istat_reg <= 3'h0;
      imask_reg <= 3'h0;
      irq_reg <= 1'b0;
      rdata_reg <= `PIFC_RST_WORD;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      lvl_a_reg <= lvl_a_next;
      lvl_b_reg <= lvl_b_next;
      lvl_u_reg <= lvl_u_next;
      detect_reg <= detect_next;
      edge_reg <= edge_next;
      irn_reg <= irn_next;
      irn_lvl_reg <= irn_lvl_next;
      stack_reg <= stack_next;
      fen_reg <= fen_next;
      fraw_reg <= fraw_next;
      fstat_reg <= fstat_next;
      freq_reg <= freq_next;
      nreq_reg <= nreq_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign fast_req_to_core = freq_reg;
  assign normal_req_to_core = nreq_reg;
  assign irq_out = irq_reg;

  // ****************************************
  // Checks
  // ****************************************
  fast_raw_a: assert property (@(posedge clock) disable iff (!rst_n)
    sync2_reg[0] |=> fraw_reg) else $error("raw fast flag not set");
  fast_line_a: assert property (@(posedge clock) disable iff (!rst_n)
    freq_reg == $past(sync2_reg[0] && fen_reg)) else $error("fast line wrong");
  fast_status_a: assert property (@(posedge clock) disable iff (!rst_n)
    freq_reg |-> fstat_reg && fraw_reg) else $error("fast status not set");
  level_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    nreq_reg |-> $past(best_lvl > current_level_encode)) else $error("request without higher level");
  winner_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    (qualify && !irn_rd) |=> irn_reg == $past(best_src) && nreq_reg)
    else $error("winner not loaded");
  idle_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    !qualify |=> irn_reg == 5'h0 && !nreq_reg) else $error("idle source number not zero");
  read_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    irn_rd |=> irn_reg == 5'h0 && !nreq_reg) else $error("read did not clear");
  ack_push_a: assert property (@(posedge clock) disable iff (!rst_n)
    (irn_rd && nreq_reg && irn_lvl_reg > current_level_encode) |=> current_level_encode == $past(irn_lvl_reg))
    else $error("accepted level not pushed");
  pop_top_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr && addr == `PIFC_OFF_POP && !irn_rd && current_level_encode != 3'h0) |=> current_level_encode < $past(current_level_encode))
    else $error("pop left top bit");
  edge_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    edge_set[0] |=> edge_reg[0]) else $error("edge not latched");

endmodule : pifc_controller
